// File: inc/sbc_pkg.sv
// sbc_pkg: shared constants for the baud generator and sync clock block
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
package sbc_pkg;

  // ----------------------------------------
  // register map: offsets are word indexes, byte address is four times each
  // ----------------------------------------
  localparam int SBC_AW = 12;                         // bus address width
  localparam logic [7:0] SBC_IDX_DIV_LOW = 8'hc4;     // baud_divisor_low_byte
  localparam logic [7:0] SBC_IDX_DIV_HIGH = 8'hc5;    // baud_divisor_high_nibble
  localparam logic [7:0] SBC_IDX_CTRL = 8'hc6;        // mode control
  localparam logic [7:0] SBC_IDX_STATUS = 8'hc7;      // generator status
  localparam logic [11:0] SBC_ADDR_DIV_LOW = {2'h0, SBC_IDX_DIV_LOW, 2'h0};
  localparam logic [11:0] SBC_ADDR_DIV_HIGH = {2'h0, SBC_IDX_DIV_HIGH, 2'h0};
  localparam logic [11:0] SBC_ADDR_CTRL = {2'h0, SBC_IDX_CTRL, 2'h0};
  localparam logic [11:0] SBC_ADDR_STATUS = {2'h0, SBC_IDX_STATUS, 2'h0};

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int SBC_DIV_W = 12;            // baud divisor width
  localparam int SBC_DIV_HI_LSB = 8;        // high nibble position in divisor
  localparam int SBC_CTRL_POL_BIT = 0;      // sync_clock_polarity
  localparam int SBC_CTRL_DSPD_BIT = 1;     // double_speed
  localparam int SBC_CTRL_MODE_BIT = 2;     // sync_mode_select

  // ----------------------------------------
  // reset values and divide ratios
  // ----------------------------------------
  localparam logic [7:0] SBC_DIV_LOW_RST = 8'h00;
  localparam logic [3:0] SBC_DIV_HIGH_RST = 4'h0;
  localparam logic [2:0] SBC_CTRL_RST = 3'h0;
  localparam logic [4:0] SBC_OVS_NORMAL = 5'h10;  // divide by 16
  localparam logic [4:0] SBC_OVS_DOUBLE = 5'h08;  // divide by 8

  // axi response codes
  localparam logic [1:0] SBC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBC_RESP_SLVERR = 2'h2;

endpackage

// File: core/sbc_regfile.sv
// sbc_regfile: axi4-lite slave holding divisor and control registers
// assumes one outstanding write and one outstanding read at a time
`timescale 1ns/1ps

module sbc_regfile
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [SBC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [SBC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register contents
  output logic [SBC_DIV_W-1:0] div_q,
  output logic [2:0] ctrl_q,
  output logic reload_pulse,
  // status input
  input wire logic [31:0] status_word
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [SBC_AW-1:0] awaddr_q, awaddr_d;  // captured write address
  logic aw_have_q, aw_have_d;         // address captured
  logic [31:0] wdata_q, wdata_d;      // captured write data
  logic w_have_q, w_have_d;           // data captured
  logic wstrb0_q, wstrb0_d;           // low byte lane enable
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] lo_q, lo_d;             // divisor low byte
  logic [3:0] hi_q, hi_d;             // divisor high nibble
  logic [2:0] ctl_q, ctl_d;           // control bits
  logic reload_q, reload_d;           // low byte written

  // decode a byte address into a known register
  function automatic logic sbc_mapped(input logic [SBC_AW-1:0] a);
    sbc_mapped = (a == SBC_ADDR_DIV_LOW) || (a == SBC_ADDR_DIV_HIGH) ||
                 (a == SBC_ADDR_CTRL) || (a == SBC_ADDR_STATUS);
  endfunction

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    awaddr_d = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d = wdata_q;
    w_have_d = w_have_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    lo_d = lo_q;
    hi_d = hi_q;
    ctl_d = ctl_q;
    reload_d = 1'b0;
    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_d = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
      w_have_d = 1'b1;
    end
    // commit once both halves are held
    if (aw_have_q && w_have_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = sbc_mapped(awaddr_q) ? SBC_RESP_OKAY : SBC_RESP_SLVERR;
      if (wstrb0_q)
      begin
        case (awaddr_q)
          SBC_ADDR_DIV_LOW:
          begin
            lo_d = wdata_q[7:0];
            reload_d = 1'b1;
          end
          // reserved upper bits of the high byte are not stored
          SBC_ADDR_DIV_HIGH: hi_d = wdata_q[3:0];
          SBC_ADDR_CTRL: ctl_d = wdata_q[2:0];
          default: ;
        endcase
      end
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // read: answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = sbc_mapped(s_axi_araddr) ? SBC_RESP_OKAY : SBC_RESP_SLVERR;
      case (s_axi_araddr)
        SBC_ADDR_DIV_LOW: rdata_d = {24'h000000, lo_q};
        SBC_ADDR_DIV_HIGH: rdata_d = {28'h0000000, hi_q};
        SBC_ADDR_CTRL: rdata_d = {29'h00000000, ctl_q};
        SBC_ADDR_STATUS: rdata_d = status_word;
        default: rdata_d = 32'h00000000;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q <= 12'h000;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      w_have_q <= 1'b0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= SBC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= SBC_RESP_OKAY;
      rdata_q <= 32'h00000000;
      lo_q <= SBC_DIV_LOW_RST;
      hi_q <= SBC_DIV_HIGH_RST;
      ctl_q <= SBC_CTRL_RST;
      reload_q <= 1'b0;
    end
    else
    begin
      awaddr_q <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q <= wdata_d;
      w_have_q <= w_have_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      ctl_q <= ctl_d;
      reload_q <= reload_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign div_q = {hi_q, lo_q};
  assign ctrl_q = ctl_q;
  assign reload_pulse = reload_q;

endmodule

// File: core/sbc_baud_gen.sv
// sbc_baud_gen: baud prescaler, oversample divider and sync clock edges
// assumes external_serial_clock arrives synchronous to aclk
`timescale 1ns/1ps

module sbc_baud_gen
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [SBC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [SBC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial line side
  input wire logic external_serial_clock,
  // timing strobes and control levels to the transceiver
  output logic prescale_tick,
  output logic baud_tick,
  output logic tx_launch,
  output logic rx_sample,
  output logic sync_mode_select,
  output logic sync_clock_polarity,
  output logic double_speed
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [SBC_DIV_W-1:0] baud_divisor;   // committed divisor bits
  logic [2:0] ctrl;                     // control bits
  logic reload;                         // low byte just written
  logic [31:0] status_word;             // live generator state

  sbc_regfile sbc_regfile_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .div_q(baud_divisor),
    .ctrl_q(ctrl),
    .reload_pulse(reload),
    .status_word(status_word)
  );

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  // mode, polarity and speed leave as levels; the transceiver must not
  // rely on polarity while the mode bit says asynchronous
  assign sync_mode_select = ctrl[SBC_CTRL_MODE_BIT];
  assign sync_clock_polarity = ctrl[SBC_CTRL_POL_BIT];
  assign double_speed = ctrl[SBC_CTRL_DSPD_BIT];

  // ----------------------------------------
  // prescaler and oversample divider state
  // ----------------------------------------
  logic [SBC_DIV_W-1:0] active_div_q, active_div_d;  // divisor in use
  logic [SBC_DIV_W-1:0] pre_cnt_q, pre_cnt_d;        // down counter
  logic [4:0] ovs_cnt_q, ovs_cnt_d;                  // oversample count
  logic pre_tick_q, pre_tick_d;
  logic baud_q, baud_d;
  logic xck_prev_q, xck_prev_d;                      // last clock level
  logic launch_q, launch_d;
  logic sample_q, sample_d;
  logic [4:0] ovs_ratio;                             // 16 or 8
  logic xck_rise;
  logic xck_fall;

  // ----------------------------------------
  // oversample ratio and serial clock edges
  // ----------------------------------------
  // eight-fold oversampling halves the bit time
  assign ovs_ratio = double_speed ? SBC_OVS_DOUBLE : SBC_OVS_NORMAL;
  // the previous level resets low, the idle level of the line clock, so
  // no false rising edge follows reset
  assign xck_rise = external_serial_clock && !xck_prev_q;
  assign xck_fall = !external_serial_clock && xck_prev_q;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // one pass computes the prescaler, the oversample divider and the edges
  always_comb
  begin
    active_div_d = active_div_q;
    pre_cnt_d = pre_cnt_q;
    ovs_cnt_d = ovs_cnt_q;
    pre_tick_d = 1'b0;
    baud_d = 1'b0;
    launch_d = 1'b0;
    sample_d = 1'b0;
    xck_prev_d = external_serial_clock;
    // a reload wins over an expiring count in the same cycle, so the old
    // divisor never yields one more tick after the low byte is written
    if (reload)
    begin
      // abandon the running count, start over with the new divisor
      active_div_d = baud_divisor;
      pre_cnt_d = baud_divisor;
      ovs_cnt_d = 5'h00;
    end
    else if (pre_cnt_q == '0)
    begin
      // divisor n gives one tick every n+1 cycles, zero every cycle
      pre_cnt_d = active_div_q;
      pre_tick_d = 1'b1;
      if (!sync_mode_select)
      begin
        if (ovs_cnt_q >= ovs_ratio - 5'h01)
        begin
          ovs_cnt_d = 5'h00;
          baud_d = 1'b1;
        end
        else
          ovs_cnt_d = ovs_cnt_q + 5'h01;
      end
    end
    else
      pre_cnt_d = pre_cnt_q - 12'h001;
    // synchronous mode: edges of the external clock time the data
    // strobes land one cycle after the pin edge: the live pin is compared
    // with the registered previous level, and only the strobe is registered
    if (sync_mode_select)
    begin
      if (sync_clock_polarity)
      begin
        launch_d = xck_fall;
        sample_d = xck_rise;
      end
      else
      begin
        launch_d = xck_rise;
        sample_d = xck_fall;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // synchronous reset; every register clears to its idle level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      active_div_q <= '0;
      pre_cnt_q <= '0;
      ovs_cnt_q <= 5'h00;
      pre_tick_q <= 1'b0;
      baud_q <= 1'b0;
      xck_prev_q <= 1'b0;
      launch_q <= 1'b0;
      sample_q <= 1'b0;
    end
    else
    begin
      active_div_q <= active_div_d;
      pre_cnt_q <= pre_cnt_d;
      ovs_cnt_q <= ovs_cnt_d;
      pre_tick_q <= pre_tick_d;
      baud_q <= baud_d;
      xck_prev_q <= xck_prev_d;
      launch_q <= launch_d;
      sample_q <= sample_d;
    end
  end

  // ----------------------------------------
  // status and outputs
  // ----------------------------------------
  // status: divisor in use and oversample count
  assign status_word = {11'h000, ovs_cnt_q, 4'h0, active_div_q};
  assign prescale_tick = pre_tick_q;
  assign baud_tick = baud_q;
  assign tx_launch = launch_q;
  assign rx_sample = sample_q;

endmodule

// File: tb/sbc_baud_gen_props.sv
// sbc_baud_gen_props: bus and serial clock edge checks on the top ports
// assumes bind into sbc_baud_gen, single aclk domain
`timescale 1ns/1ps

module sbc_baud_gen_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // line side and strobes
  input wire logic external_serial_clock,
  input wire logic baud_tick,
  input wire logic tx_launch,
  input wire logic rx_sample,
  input wire logic sync_mode_select,
  input wire logic sync_clock_polarity
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  launch_rise_a: assert property (
    $rose(external_serial_clock) && sync_mode_select && !sync_clock_polarity
    |-> ##[1:3] tx_launch) else $error("no launch on rising edge");
  sample_fall_a: assert property (
    $fell(external_serial_clock) && sync_mode_select && !sync_clock_polarity
    |-> ##[1:3] rx_sample) else $error("no sample on falling edge");
  launch_fall_a: assert property (
    $fell(external_serial_clock) && sync_mode_select && sync_clock_polarity
    |-> ##[1:3] tx_launch) else $error("no launch on falling edge");
  sample_rise_a: assert property (
    $rose(external_serial_clock) && sync_mode_select && sync_clock_polarity
    |-> ##[1:3] rx_sample) else $error("no sample on rising edge");
  async_quiet_a: assert property (
    !sync_mode_select && !$past(sync_mode_select) && !$past(sync_mode_select, 2)
    |-> !tx_launch && !rx_sample) else $error("edge strobe in async mode");
  baud_async_a: assert property (
    baud_tick |-> !(sync_mode_select && $past(sync_mode_select)))
    else $error("baud tick in sync mode");
endmodule

bind sbc_baud_gen sbc_baud_gen_props sbc_baud_gen_props_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .external_serial_clock, .baud_tick, .tx_launch, .rx_sample,
  .sync_mode_select, .sync_clock_polarity);

// File: tb/sbc_station.sv
// sbc_station: remote station making bursts of the external serial clock
// assumes start is a one-cycle request; clock idles low between bursts
`timescale 1ns/1ps

module sbc_station #(parameter int HALF = 6, parameter int EDGES = 8) (
  // clock and request
  input wire logic aclk,
  input wire logic start,
  // line side
  output logic external_serial_clock,
  output logic busy
);
  int cnt = 0;
  int edges = 0;
  initial external_serial_clock = 1'b0;
  initial busy = 1'b0;
  // toggle every HALF cycles, rising edge first, ending low
  always @(posedge aclk)
    if (!busy)
      busy <= start;
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      external_serial_clock <= ~external_serial_clock;
      edges <= edges + 1;
      if (edges == EDGES - 1)
      begin
        busy <= 1'b0;
        edges <= 0;
      end
    end
    else
      cnt <= cnt + 1;
endmodule

// File: tb/sbc_baud_gen_bench.sv
// sbc_baud_gen_bench: register traffic, tick periods and sync edge strobes
// assumes sbc_baud_gen as top and sbc_station on the serial clock
`timescale 1ns/1ps

module sbc_baud_gen_bench
  import sbc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 0, aresetn = 0, start = 0, busy;
  logic [SBC_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic external_serial_clock, prescale_tick, baud_tick, tx_launch, rx_sample;
  logic sync_mode_select, sync_clock_polarity, double_speed;
  int err_total = 0, check_count = 0;

  always #2 aclk = ~aclk;

  sbc_baud_gen sbc_baud_gen_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_serial_clock, .prescale_tick,
    .baud_tick, .tx_launch, .rx_sample, .sync_mode_select, .sync_clock_polarity,
    .double_speed);
  sbc_station sbc_station_i (.aclk, .start, .external_serial_clock, .busy);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // write one word, answer checked against er
  task automatic wr(input logic [SBC_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_bvalid; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("write timeout", 32'(n == 50), 32'h0);
    if (n == 50) end_sim();
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  // read one word, data and response checked
  task automatic rd(input logic [SBC_AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_rvalid; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("read timeout", 32'(n == 50), 32'h0);
    if (n == 50) end_sim();
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  // first tick within bound, then cycles to the next one
  task automatic meas(input logic sel, input int bound, input int exp);
    int n, p;
    for (n = 0; n < bound && !(sel ? baud_tick : prescale_tick); n++)
      @(posedge aclk);
    chk("first tick", 32'(n < bound), 32'h1);
    p = 0;
    do
    begin
      @(posedge aclk);
      p++;
    end
    while (!(sel ? baud_tick : prescale_tick) && p < 6000);
    chk(sel ? "baud period" : "prescale period", 32'(p), 32'(exp));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(SBC_ADDR_DIV_LOW, 32'h0, SBC_RESP_OKAY);
    rd(SBC_ADDR_DIV_HIGH, 32'h0, SBC_RESP_OKAY);
    rd(SBC_ADDR_CTRL, 32'h0, SBC_RESP_OKAY);
    // oversample count runs every cycle at divisor zero: ten at the sampling edge
    rd(SBC_ADDR_STATUS, 32'h000a_0000, SBC_RESP_OKAY);
    meas(1'b0, 4, 1);
    meas(1'b1, 40, 16);
  endtask

  task automatic t_div();
    wr(SBC_ADDR_DIV_HIGH, 32'h5, SBC_RESP_OKAY);
    rd(SBC_ADDR_DIV_HIGH, 32'h5, SBC_RESP_OKAY);
    rd(SBC_ADDR_STATUS, 32'h0009_0000, SBC_RESP_OKAY);
    meas(1'b0, 4, 1);
    wr(SBC_ADDR_DIV_LOW, 32'h3, SBC_RESP_OKAY);
    rd(SBC_ADDR_STATUS, 32'h0000_0503, SBC_RESP_OKAY);
    meas(1'b0, 2000, 32'h504);
    wr(SBC_ADDR_DIV_HIGH, 32'h0, SBC_RESP_OKAY);
    wr(SBC_ADDR_DIV_LOW, 32'h2, SBC_RESP_OKAY);
    meas(1'b0, 8, 3);
    meas(1'b1, 60, 48);
    wr(SBC_ADDR_CTRL, 32'h2, SBC_RESP_OKAY);
    chk("double_speed", 32'(double_speed), 32'h1);
    meas(1'b1, 60, 24);
    wr(SBC_ADDR_DIV_LOW, 32'h0, SBC_RESP_OKAY);
    meas(1'b1, 20, 8);
    rd(12'h0d0, 32'h0, SBC_RESP_SLVERR);
    wr(12'h0d0, 32'h1, SBC_RESP_SLVERR);
  endtask

  // one burst of 8 serial clock edges; strobes counted and levels checked
  task automatic t_link(input logic [2:0] ctl, input int exp);
    int n, tx, rx;
    tx = 0;
    rx = 0;
    wr(SBC_ADDR_CTRL, 32'(ctl), SBC_RESP_OKAY);
    chk("mode", 32'(sync_mode_select), 32'(ctl[2]));
    chk("polarity", 32'(sync_clock_polarity), 32'(ctl[0]));
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (n = 0; n < 70; n++)
    begin
      @(posedge aclk);
      if (tx_launch)
      begin
        tx++;
        chk("launch level", 32'(external_serial_clock), 32'(!ctl[0]));
      end
      if (rx_sample)
      begin
        rx++;
        chk("sample level", 32'(external_serial_clock), 32'(ctl[0]));
      end
    end
    chk("station idle", 32'(busy), 32'h0);
    chk("launch count", 32'(tx), 32'(exp));
    chk("sample count", 32'(rx), 32'(exp));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_div();
    t_link(3'h4, 4);
    t_link(3'h5, 4);
    t_link(3'h1, 0);
    end_sim();
  end
endmodule
